// file: rtl/gpio_pkg.sv
// Constants and types for the port pin control block
package gpio_pkg;
  // Bus geometry
  localparam int AW = 15;
  localparam int DW = 32;
  localparam int IW = 13;

  // Register indexes; byte address is four times the index
  localparam logic [IW-1:0] IDX_OPEN_DRAIN = 13'h1F3A;
  localparam logic [IW-1:0] IDX_FLAGS      = 13'h1F3F;
  localparam logic [IW-1:0] IDX_SLEW       = 13'h1F51;
  localparam logic [IW-1:0] IDX_RISE_EN    = 13'h1F53;
  localparam logic [IW-1:0] IDX_LATCH      = 13'h1F60;
  localparam logic [IW-1:0] IDX_TRIS       = 13'h1F61;
  localparam logic [IW-1:0] IDX_ANALOG_SEL = 13'h1F62;
  localparam logic [IW-1:0] IDX_FALL_EN    = 13'h1F63;
  localparam logic [IW-1:0] IDX_PERIPH_SEL = 13'h1F64;
  localparam logic [IW-1:0] IDX_PIN_LEVEL  = 13'h1F65;
  localparam logic [IW-1:0] IDX_IRQ_STATUS = 13'h1F66;
  localparam logic [IW-1:0] IDX_IRQ_MASK   = 13'h1F67;

  // Values after reset
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_SLEW       = 8'hFF;
  localparam logic [7:0] RST_RISE_EN    = 8'h00;
  localparam logic [7:0] RST_LATCH      = 8'h00;
  localparam logic [7:0] RST_TRIS       = 8'hFF;
  localparam logic [7:0] RST_ANALOG_SEL = 8'h00;
  localparam logic [7:0] RST_FALL_EN    = 8'h00;
  localparam logic [7:0] RST_PERIPH_SEL = 8'h00;
  localparam logic [1:0] RST_IRQ        = 2'h0;

  // Interrupt status bit positions
  localparam int STAT_RISE = 0;
  localparam int STAT_FALL = 1;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;
endpackage

// file: rtl/port_pin_ctrl.sv
// Port pin control with function priority and change detection
//
// Design decision made here: the Avalon-MM register port.
module port_pin_ctrl #(
  parameter int PINS = 8
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Avalon-MM slave
  input  wire logic [gpio_pkg::AW-1:0]   address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [3:0]                byteenable,
  input  wire logic [gpio_pkg::DW-1:0]   writedata,
  output logic      [gpio_pkg::DW-1:0]   readdata,
  output logic                           waitrequest,
  // Higher priority pin owners
  input  wire logic [PINS-1:0]           cfg_own,
  input  wire logic [PINS-1:0]           cfg_out,
  input  wire logic [PINS-1:0]           cfg_oe,
  input  wire logic [PINS-1:0]           analog_out_en,
  // Peripheral pin selection sources
  input  wire logic [PINS-1:0]           periph_out,
  input  wire logic [PINS-1:0]           periph_oe,
  // Pads
  input  wire logic [PINS-1:0]           pin_in,
  output logic      [PINS-1:0]           pin_out,
  output logic      [PINS-1:0]           pin_oe,
  output logic      [PINS-1:0]           slew_limit,
  output logic      [PINS-1:0]           input_buf_en,
  output logic      [PINS-1:0]           analog_in_en,
  // Interrupts
  output logic                           change_irq,
  output logic                           irq
);

  if (PINS != 8) begin : g_pins_check
    $error("PINS must be 8");
  end

  gpio_pkg::bus_state_e bus_state_reg;
  logic [gpio_pkg::DW-1:0] readdata_reg;
  logic [gpio_pkg::DW-1:0] readdata_next;
  logic [gpio_pkg::IW-1:0] idx;
  logic                    acc;
  logic                    wr_acc;
  logic                    rd_acc;
  logic                    wait_reg;

  logic [7:0] open_drain_sel_reg;
  logic [7:0] change_flag_reg;
  logic [7:0] change_flag_next;
  logic [7:0] slew_reg;
  logic [7:0] rise_en_reg;
  logic [7:0] fall_en_reg;
  logic [7:0] latch_reg;
  logic [7:0] tris_reg;
  logic [7:0] analog_select_reg;
  logic [7:0] periph_sel_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_mask_reg;

  logic [7:0] sync_a_reg;
  logic [7:0] sync_b_reg;
  logic [7:0] prev_reg;
  logic [7:0] rise_evt;
  logic [7:0] fall_evt;
  logic [7:0] hit_evt;

  logic [7:0] pin_out_reg;
  logic [7:0] pin_oe_reg;
  logic [7:0] pin_out_next;
  logic [7:0] pin_oe_next;
  logic [7:0] in_buf_reg;
  logic [7:0] ana_in_reg;
  logic       change_irq_reg;
  logic       irq_reg;

  // Write strobe for one register, low byte lane
  function automatic logic wr_hit(
    input logic [gpio_pkg::IW-1:0] a,
    input logic [gpio_pkg::IW-1:0] r,
    input logic                    w,
    input logic                    be
  );
    wr_hit = w && be && (a == r);
  endfunction

  // Byte wide write update
  function automatic logic [7:0] wr_byte(
    input logic       hit,
    input logic [7:0] old,
    input logic [7:0] data
  );
    wr_byte = hit ? data : old;
  endfunction

  assign idx    = address[gpio_pkg::AW-1:2];
  assign acc    = bus_state_reg == gpio_pkg::BUS_ACK;
  assign wr_acc = acc && write;
  assign rd_acc = acc && read;

  // Bus handshake: one wait cycle, accepted in ACK
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_state_reg <= gpio_pkg::BUS_IDLE;
      wait_reg      <= 1'b1;
    end else begin
      wait_reg <= 1'b1;
      unique case (bus_state_reg)
        gpio_pkg::BUS_IDLE: begin
          if (read || write) begin
            bus_state_reg <= gpio_pkg::BUS_ACK;
            wait_reg      <= 1'b0;
          end
        end
        gpio_pkg::BUS_ACK: begin
          bus_state_reg <= gpio_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_reg <= gpio_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    readdata_next = '0;
    unique case (idx)
      gpio_pkg::IDX_OPEN_DRAIN: readdata_next[7:0] = open_drain_sel_reg;
      gpio_pkg::IDX_FLAGS:      readdata_next[7:0] = change_flag_reg;
      gpio_pkg::IDX_SLEW:       readdata_next[7:0] = slew_reg;
      gpio_pkg::IDX_RISE_EN:    readdata_next[7:0] = rise_en_reg;
      gpio_pkg::IDX_LATCH:      readdata_next[7:0] = latch_reg;
      gpio_pkg::IDX_TRIS:       readdata_next[7:0] = tris_reg;
      gpio_pkg::IDX_ANALOG_SEL: readdata_next[7:0] = analog_select_reg;
      gpio_pkg::IDX_FALL_EN:    readdata_next[7:0] = fall_en_reg;
      gpio_pkg::IDX_PERIPH_SEL: readdata_next[7:0] = periph_sel_reg;
      gpio_pkg::IDX_PIN_LEVEL:  readdata_next[7:0] = sync_b_reg & in_buf_reg;
      gpio_pkg::IDX_IRQ_STATUS: readdata_next[1:0] = irq_status_reg;
      gpio_pkg::IDX_IRQ_MASK:   readdata_next[1:0] = irq_mask_reg;
      default:                  readdata_next = '0;
    endcase
  end

  // Read data captured while waitrequest is still high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      readdata_reg <= '0;
    end else if (!acc && read) begin
      readdata_reg <= readdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      open_drain_sel_reg <= gpio_pkg::RST_OPEN_DRAIN;
      slew_reg           <= gpio_pkg::RST_SLEW;
      rise_en_reg        <= gpio_pkg::RST_RISE_EN;
      fall_en_reg        <= gpio_pkg::RST_FALL_EN;
    end else begin
      open_drain_sel_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_OPEN_DRAIN,
        wr_acc, byteenable[0]), open_drain_sel_reg, writedata[7:0]);
      slew_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_SLEW,
        wr_acc, byteenable[0]), slew_reg, writedata[7:0]);
      rise_en_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_RISE_EN,
        wr_acc, byteenable[0]), rise_en_reg, writedata[7:0]);
      fall_en_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_FALL_EN,
        wr_acc, byteenable[0]), fall_en_reg, writedata[7:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      latch_reg         <= gpio_pkg::RST_LATCH;
      tris_reg          <= gpio_pkg::RST_TRIS;
      analog_select_reg <= gpio_pkg::RST_ANALOG_SEL;
      periph_sel_reg    <= gpio_pkg::RST_PERIPH_SEL;
      irq_mask_reg      <= gpio_pkg::RST_IRQ;
    end else begin
      latch_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_LATCH,
        wr_acc, byteenable[0]), latch_reg, writedata[7:0]);
      tris_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_TRIS,
        wr_acc, byteenable[0]), tris_reg, writedata[7:0]);
      analog_select_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_ANALOG_SEL,
        wr_acc, byteenable[0]), analog_select_reg, writedata[7:0]);
      periph_sel_reg <= wr_byte(wr_hit(idx, gpio_pkg::IDX_PERIPH_SEL,
        wr_acc, byteenable[0]), periph_sel_reg, writedata[7:0]);
      if (wr_hit(idx, gpio_pkg::IDX_IRQ_MASK, wr_acc, byteenable[0])) begin
        irq_mask_reg <= writedata[1:0];
      end
    end
  end

  // Two stage synchroniser, then a compare stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
      prev_reg   <= '0;
    end else begin
      sync_a_reg <= pin_in;
      sync_b_reg <= sync_a_reg;
      prev_reg   <= sync_b_reg;
    end
  end

  assign rise_evt = sync_b_reg & ~prev_reg & rise_en_reg;
  assign fall_evt = ~sync_b_reg & prev_reg & fall_en_reg;
  assign hit_evt  = rise_evt | fall_evt;

  // Software write stores, a new edge always wins
  always_comb begin
    change_flag_next = change_flag_reg;
    if (wr_hit(idx, gpio_pkg::IDX_FLAGS, wr_acc, byteenable[0])) begin
      change_flag_next = writedata[7:0];
    end
    change_flag_next = change_flag_next | hit_evt;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      change_flag_reg <= gpio_pkg::RST_FLAGS;
    end else begin
      change_flag_reg <= change_flag_next;
    end
  end

  // Sticky event status, cleared by a read, set wins
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_acc && idx == gpio_pkg::IDX_IRQ_STATUS) begin
      irq_status_next = '0;
    end
    irq_status_next[gpio_pkg::STAT_RISE] =
      irq_status_next[gpio_pkg::STAT_RISE] | (|rise_evt);
    irq_status_next[gpio_pkg::STAT_FALL] =
      irq_status_next[gpio_pkg::STAT_FALL] | (|fall_evt);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_status_reg <= gpio_pkg::RST_IRQ;
      irq_reg        <= 1'b0;
      change_irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_reg        <= |(irq_status_next & irq_mask_reg);
      change_irq_reg <= |change_flag_next;
    end
  end

  // Pin owner resolution, highest priority first
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (cfg_own[i]) begin
        pin_out_next[i] = cfg_out[i];
        pin_oe_next[i]  = cfg_oe[i];
      end else if (analog_out_en[i]) begin
        pin_out_next[i] = 1'b0;
        pin_oe_next[i]  = 1'b0;
      end else if (periph_sel_reg[i]) begin
        pin_out_next[i] = periph_out[i];
        pin_oe_next[i]  = periph_oe[i] &
          ~(open_drain_sel_reg[i] & periph_out[i]);
      end else begin
        pin_out_next[i] = latch_reg[i];
        pin_oe_next[i]  = ~tris_reg[i] &
          ~(open_drain_sel_reg[i] & latch_reg[i]);
      end
    end
  end

  // Analog select does not gate digital drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_buf_reg <= '0;
      ana_in_reg <= '0;
    end else begin
      in_buf_reg <= ~analog_select_reg & ~analog_out_en;
      ana_in_reg <= analog_select_reg & ~analog_out_en &
        ~cfg_own;
    end
  end

  assign readdata     = readdata_reg;
  assign waitrequest  = wait_reg;
  assign pin_out      = pin_out_reg;
  assign pin_oe       = pin_oe_reg;
  assign slew_limit   = slew_reg;
  assign input_buf_en = in_buf_reg;
  assign analog_in_en = ana_in_reg;
  assign change_irq   = change_irq_reg;
  assign irq          = irq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rise_seen;
    (|rise_evt);
  endsequence

  sequence s_flag_up;
    ((change_flag_reg & $past(rise_evt)) == $past(rise_evt)) ##0 change_irq;
  endsequence

  a_latch_owns_pin: assert property (1'b1 |=> ((pin_out_reg ^
    $past(latch_reg)) & $past(~cfg_own & ~analog_out_en &
    ~periph_sel_reg)) == '0)
    else $error("pin not driven by latch");

  a_analog_in_gate: assert property (1'b1 |=>
    (ana_in_reg & ~$past(analog_select_reg)) == '0)
    else $error("analog input active outside analog mode");

  a_analog_digital: assert property (1'b1 |=> (pin_oe_reg &
    $past(analog_select_reg & ~tris_reg & ~cfg_own & ~analog_out_en &
    ~periph_sel_reg & ~latch_reg)) == $past(analog_select_reg &
    ~tris_reg & ~cfg_own & ~analog_out_en & ~periph_sel_reg &
    ~latch_reg))
    else $error("digital drive lost in analog mode");

  a_analog_out_hiz: assert property (1'b1 |=>
    (pin_oe_reg & $past(analog_out_en & ~cfg_own)) == '0)
    else $error("driver on under analog output");

  a_cfg_priority: assert property (1'b1 |=>
    ((pin_oe_reg ^ $past(cfg_oe)) & $past(cfg_own)) == '0)
    else $error("configuration owner overridden");

  a_open_drain: assert property (1'b1 |=>
    (pin_oe_reg & pin_out_reg & $past(open_drain_sel_reg & ~cfg_own)) == '0)
    else $error("open-drain pin driven high");

  a_od_reset: assert property (disable iff (1'b0)
    !rstn |=> open_drain_sel_reg == '0 && slew_limit == 8'hFF)
    else $error("reset values wrong");

  a_slew_write: assert property (wr_acc && byteenable[0] &&
    idx == gpio_pkg::IDX_SLEW |=> slew_limit == $past(writedata[7:0]))
    else $error("slew write lost");

  a_rise_flag: assert property (s_rise_seen |=> s_flag_up)
    else $error("rising edge flag or interrupt missing");

  a_fall_flag: assert property ((|fall_evt) |=>
    (change_flag_reg & $past(fall_evt)) == $past(fall_evt))
    else $error("falling edge flag missing");

  a_flag_clear: assert property (wr_acc && byteenable[0] &&
    idx == gpio_pkg::IDX_FLAGS && writedata[7:0] == 8'h00 &&
    hit_evt == '0 |=> change_flag_reg == '0)
    else $error("flag clear ignored");

  a_rise_off: assert property (!(wr_acc &&
    idx == gpio_pkg::IDX_FLAGS) |=> (change_flag_reg &
    ~$past(change_flag_reg) & ~$past(hit_evt)) == '0)
    else $error("flag set without enabled edge");

  a_pin_sync: assert property ($rose(pin_in[0]) &&
    rise_en_reg[0] ##1 pin_in[0] [*3] ##0 $stable(rise_en_reg) |->
    change_flag_reg[0])
    else $error("synchronised edge not seen in three cycles");

endmodule

// file: dv/pin_partner.sv
// Pad model: resolves each pad from the block's drive and the outside level
module pin_partner #(
  parameter int PINS = 8
) (
  // Block side
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe,
  // Outside world
  input  wire logic [PINS-1:0] ext_level,
  output logic      [PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released pads follow the outside source, driven ones the block
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule

// file: dv/tb_port_pin_ctrl.sv
// Self-checking bench for the port pin control block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("ERROR %s expected %h seen %h", n, e, g); miscompares++; end end

module tb_port_pin_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  logic                        clk = 1'b0;
  logic                        rstn = 1'b0;
  logic [gpio_pkg::AW-1:0]     address = '0;
  logic                        read = 1'b0;
  logic                        write = 1'b0;
  logic [3:0]                  byteenable = 4'h0;
  logic [gpio_pkg::DW-1:0]     writedata = '0;
  logic [gpio_pkg::DW-1:0]     readdata;
  logic                        waitrequest;
  logic [7:0]                  cfg_own = 8'h00;
  logic [7:0]                  cfg_out = 8'h00;
  logic [7:0]                  cfg_oe = 8'h00;
  logic [7:0]                  analog_out_en = 8'h00;
  logic [7:0]                  periph_out = 8'h00;
  logic [7:0]                  periph_oe = 8'h00;
  logic [7:0]                  ext_level = 8'h00;
  logic [7:0]                  pin_in;
  logic [7:0]                  pin_out;
  logic [7:0]                  pin_oe;
  logic [7:0]                  slew_limit;
  logic [7:0]                  input_buf_en;
  logic [7:0]                  analog_in_en;
  logic                        change_irq;
  logic                        irq;
  logic [gpio_pkg::DW-1:0]     rd_val;
  int                          miscompares = 0;
  int                          comparisons = 0;

  always #5 clk = ~clk;

  port_pin_ctrl #(.PINS(8)) u_port_pin_ctrl (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cfg_own(cfg_own), .cfg_out(cfg_out),
    .cfg_oe(cfg_oe), .analog_out_en(analog_out_en), .periph_out(periph_out),
    .periph_oe(periph_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .slew_limit(slew_limit), .input_buf_en(input_buf_en),
    .analog_in_en(analog_in_en), .change_irq(change_irq), .irq(irq)
  );

  pin_partner #(.PINS(8)) u_pin_partner (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in)
  );

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hold the request until waitrequest is sampled low
  task automatic wait_ack;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      $display("ERROR bus timeout");
      miscompares++;
      conclude();
    end
  endtask

  task automatic wr(input logic [12:0] idx, input logic [7:0] d);
    @(posedge clk);
    address    <= {idx, 2'b00};
    writedata  <= {24'h0, d};
    byteenable <= 4'hF;
    write      <= 1'b1;
    wait_ack();
    write <= 1'b0;
  endtask

  task automatic rd(input logic [12:0] idx);
    @(posedge clk);
    address <= {idx, 2'b00};
    read    <= 1'b1;
    wait_ack();
    rd_val = readdata;
    read <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    settle(4);
    rstn <= 1'b1;
    settle(2);
    // Reset values and unmapped place
    `CHK("pin_oe", 8'h00, pin_oe)
    rd(gpio_pkg::IDX_OPEN_DRAIN);
    `CHK("open_drain", 8'h00, rd_val)
    rd(gpio_pkg::IDX_SLEW);
    `CHK("slew", 8'hFF, rd_val)
    `CHK("slew_limit", 8'hFF, slew_limit)
    rd(gpio_pkg::IDX_FLAGS);
    `CHK("flags", 8'h00, rd_val)
    rd(gpio_pkg::IDX_RISE_EN);
    `CHK("rise_en", 8'h00, rd_val)
    rd(13'h0000);
    `CHK("unmapped", 8'h00, rd_val)
    // Slew write and slew output
    wr(gpio_pkg::IDX_SLEW, 8'h0F);
    settle(2);
    `CHK("slew_limit", 8'h0F, slew_limit)
    // Edges with both enables off, then with rise and fall enables on
    ext_level <= 8'hFF;
    settle(4);
    ext_level <= 8'h00;
    settle(4);
    rd(gpio_pkg::IDX_FLAGS);
    `CHK("flags", 8'h00, rd_val)
    wr(gpio_pkg::IDX_RISE_EN, 8'h01);
    wr(gpio_pkg::IDX_FALL_EN, 8'h02);
    wr(gpio_pkg::IDX_IRQ_MASK, 8'h03);
    rd(gpio_pkg::IDX_RISE_EN);
    `CHK("rise_en", 8'h01, rd_val)
    ext_level <= 8'h03;
    settle(4);
    `CHK("change_irq", 1'b1, change_irq)
    `CHK("irq", 1'b1, irq)
    rd(gpio_pkg::IDX_FLAGS);
    `CHK("flags", 8'h01, rd_val)
    ext_level <= 8'h00;
    settle(4);
    rd(gpio_pkg::IDX_FLAGS);
    `CHK("flags", 8'h03, rd_val)
    rd(gpio_pkg::IDX_IRQ_STATUS);
    `CHK("status", 8'h03, rd_val)
    rd(gpio_pkg::IDX_IRQ_STATUS);
    `CHK("status", 8'h00, rd_val)
    settle(2);
    `CHK("irq", 1'b0, irq)
    `CHK("change_irq", 1'b1, change_irq)
    wr(gpio_pkg::IDX_FLAGS, 8'h00);
    settle(2);
    `CHK("change_irq", 1'b0, change_irq)
    rd(gpio_pkg::IDX_FLAGS);
    `CHK("flags", 8'h00, rd_val)
    // Ownership priority on the drive side and the input enables
    cfg_own   <= 8'h02;
    cfg_oe    <= 8'h02;
    periph_oe <= 8'h08;
    wr(gpio_pkg::IDX_LATCH, 8'h5A);
    wr(gpio_pkg::IDX_TRIS, 8'h00);
    settle(2);
    `CHK("pin_out", 8'h58, pin_out)
    `CHK("pin_oe", 8'hFF, pin_oe)
    analog_out_en <= 8'h01;
    wr(gpio_pkg::IDX_ANALOG_SEL, 8'h04);
    wr(gpio_pkg::IDX_PERIPH_SEL, 8'h08);
    settle(2);
    `CHK("pin_out", 8'h50, pin_out & 8'hFE)
    `CHK("pin_oe", 8'hFE, pin_oe)
    `CHK("input_buf_en", 8'hFA, input_buf_en)
    `CHK("analog_in_en", 8'h04, analog_in_en)
    `CHK("analog_pin_oe", 1'b1, pin_oe[2])
    wr(gpio_pkg::IDX_OPEN_DRAIN, 8'hFF);
    rd(gpio_pkg::IDX_OPEN_DRAIN);
    `CHK("open_drain", 8'hFF, rd_val)
    settle(1);
    `CHK("pin_oe", 8'hAE, pin_oe)
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    $display("ERROR run timeout");
    miscompares++;
    conclude();
  end
endmodule
